// ---- rtl/operand_field_decoder.sv ----
// Operand field decoder with sequencer, shadows, table pointer and register port
`timescale 1ns/1ps
`include "ofd_map.svh"
module operand_field_decoder #(
  parameter logic [7:0] ACCESS_SPLIT = `ACC_SPLIT,
  parameter int PHASES = `CYC_PHASES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] instr_word,
  input wire ofd_pkg::instr_class_t instr_class,
  input wire logic cond_true,
  input wire ofd_pkg::flags_t flag_mask,
  input wire ofd_pkg::flags_t alu_flags,
  input wire logic [7:0] alu_result,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] table_rdata,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic cycle_en,
  output logic exec_valid,
  output ofd_pkg::instr_class_t exec_class,
  output logic nop_cycle,
  output logic [11:0] file_addr,
  output logic access_window,
  output logic dest_file,
  output logic file_we,
  output logic [7:0] file_wdata,
  output logic [2:0] bit_index,
  output logic [7:0] bit_mask,
  output logic [19:0] literal,
  output logic branch_rel,
  output logic [19:0] branch_value,
  output logic [11:0] move_src_addr,
  output logic [11:0] move_dst_addr,
  output logic table_rd,
  output logic table_wr,
  output ofd_pkg::table_mode_t table_mode,
  output logic [20:0] table_addr,
  output logic [7:0] table_wdata,
  output logic shadow_save,
  output logic shadow_restore
);
  import ofd_pkg::*;

  seq_state_t state_q;
  logic [15:0] first_q;
  instr_class_t class_q;
  logic [3:0] bank_q;
  logic [7:0] acc_q;
  flags_t status_q;
  logic [7:0] prod_lo_q;
  logic [7:0] prod_hi_q;
  logic [20:0] ptr_q;
  logic [7:0] latch_q;
  logic [3:0] sh_bank_q;
  logic [7:0] sh_acc_q;
  flags_t sh_status_q;
  logic [15:0] word1;
  logic [15:0] word2;
  instr_class_t cls;
  logic lone_second;
  logic exec_now;
  logic save_now;
  logic restore_now;
  logic tbl_now;
  table_mode_t mode_d;
  logic [11:0] addr_d;
  logic access_d;
  logic dest_d;
  logic we_d;
  logic [7:0] wdata_d;
  logic [19:0] lit_d;
  logic rel_d;
  logic [19:0] br_d;
  logic [11:0] src_d;
  logic [11:0] dst_d;
  logic [15:0] prod_full;
  logic [31:0] rd_d;

  // Instruction cycle enable
  cycle_divider #(
    .PHASES(PHASES)
  ) u_div (
    .clk(clk),
    .resetn(resetn),
    .tick(cycle_en)
  );

  function automatic logic is_double(input instr_class_t c);
    return (c == CL_MOVE_FF) || (c == CL_GOTO) || (c == CL_CALL) || (c == CL_LIT12);
  endfunction

  function automatic logic is_jump(input instr_class_t c);
    return (c == CL_BRA11) || (c == CL_RCALL) || (c == CL_RETURN);
  endfunction

  // Short address onto bank or fixed access window
  function automatic logic [11:0] map_addr(input logic [7:0] f, input logic a,
                                           input logic [3:0] bank);
    logic [3:0] hi;
    if (a) begin
      hi = bank;
    end else if (f < ACCESS_SPLIT) begin
      hi = `ACC_LO_PAGE;
    end else begin
      hi = `ACC_HI_PAGE;
    end
    return {hi, f};
  endfunction

  // Current words and execute condition
  assign lone_second = (instr_word[`FLD_TOP_MSB:`FLD_TOP_LSB] == `TOP_SECOND);
  assign word1 = (state_q == ST_SECOND) ? first_q : instr_word;
  assign word2 = instr_word;
  assign cls = (state_q == ST_SECOND) ? class_q : instr_class;
  assign exec_now = cycle_en && (((state_q == ST_FIRST) && !lone_second &&
                    !is_double(instr_class)) || (state_q == ST_SECOND));
  // Fast bit of a call sits above the low target byte, not in it
  assign save_now = exec_now && (cls == CL_CALL) && word1[`FLD_S_CALL];
  assign restore_now = exec_now && (cls == CL_RETURN) && word1[`FLD_S];
  assign tbl_now = exec_now && ((cls == CL_TBL_RD) || (cls == CL_TBL_WR));
  assign mode_d = table_mode_t'(word1[`FLD_MM_MSB:`FLD_MM_LSB]);
  assign prod_full = acc_q * file_rdata;

  // Sequencer: first word, second word, flush cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_FIRST;
      first_q <= `RST_WORD;
      class_q <= CL_NOP;
    end else if (cycle_en) begin
      unique case (state_q)
        ST_FIRST: begin
          first_q <= instr_word;
          class_q <= instr_class;
          if (!lone_second && is_double(instr_class)) begin
            state_q <= ST_SECOND;
          end else if (!lone_second && (cond_true || is_jump(instr_class))) begin
            state_q <= ST_FLUSH;
          end
        end
        ST_SECOND: state_q <= ST_FIRST;
        ST_FLUSH: state_q <= ST_FIRST;
        default: state_q <= ST_FIRST;
      endcase
    end
  end

  // Operand decode; unused encoding bits are never looked at
  always_comb begin
    addr_d = map_addr(word1[`FLD_F_MSB:`FLD_F_LSB], word1[`FLD_A], bank_q);
    access_d = !word1[`FLD_A];
    dest_d = word1[`FLD_D] && (cls == CL_BYTE);
    we_d = dest_d || (cls == CL_BIT);
    wdata_d = alu_result;
    lit_d = `RST_LIT;
    rel_d = 1'b0;
    br_d = `RST_LIT;
    src_d = move_src_addr;
    dst_d = move_dst_addr;
    unique case (cls)
      CL_LIT8: lit_d = 20'(word1[`FLD_F_MSB:`FLD_F_LSB]);
      CL_LIT12: lit_d = 20'({word1[`FLD_K4_MSB:0], word2[`FLD_F_MSB:`FLD_F_LSB]});
      CL_GOTO, CL_CALL: begin
        lit_d = {word2[`FLD_W12_MSB:0], word1[`FLD_F_MSB:`FLD_F_LSB]};
        br_d = lit_d;
      end
      CL_BRA11, CL_RCALL: begin
        rel_d = 1'b1;
        br_d = 20'($signed(word1[`FLD_N11_MSB:0]));
      end
      CL_BRANCH8: begin
        rel_d = 1'b1;
        br_d = 20'($signed(word1[`FLD_F_MSB:`FLD_F_LSB]));
      end
      CL_MOVE_FF: begin
        src_d = word1[`FLD_W12_MSB:0];
        dst_d = word2[`FLD_W12_MSB:0];
        addr_d = dst_d;
        access_d = 1'b0;
        we_d = 1'b1;
        wdata_d = file_rdata;
      end
      default: begin
        lit_d = `RST_LIT;
      end
    endcase
  end

  // Held decode outputs, updated at each executed instruction
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exec_class <= CL_NOP;
      file_addr <= `RST_ADDR;
      access_window <= 1'b0;
      dest_file <= 1'b0;
      file_wdata <= `RST_BYTE;
      bit_index <= 3'h0;
      bit_mask <= `RST_BYTE;
      literal <= `RST_LIT;
      branch_rel <= 1'b0;
      branch_value <= `RST_LIT;
      move_src_addr <= `RST_ADDR;
      move_dst_addr <= `RST_ADDR;
    end else if (exec_now) begin
      exec_class <= cls;
      file_addr <= addr_d;
      access_window <= access_d;
      dest_file <= dest_d;
      file_wdata <= wdata_d;
      bit_index <= word1[`FLD_B_MSB:`FLD_B_LSB];
      bit_mask <= `BIT_ONE << word1[`FLD_B_MSB:`FLD_B_LSB];
      literal <= lit_d;
      branch_rel <= rel_d;
      branch_value <= br_d;
      move_src_addr <= src_d;
      move_dst_addr <= dst_d;
    end
  end

  // One-cycle strobes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exec_valid <= 1'b0;
      nop_cycle <= 1'b0;
      file_we <= 1'b0;
      table_rd <= 1'b0;
      table_wr <= 1'b0;
      shadow_save <= 1'b0;
      shadow_restore <= 1'b0;
    end else begin
      exec_valid <= exec_now;
      nop_cycle <= cycle_en && ((state_q == ST_FLUSH) ||
                   ((state_q == ST_FIRST) && lone_second));
      file_we <= exec_now && we_d;
      table_rd <= tbl_now && (cls == CL_TBL_RD);
      table_wr <= tbl_now && (cls == CL_TBL_WR);
      shadow_save <= save_now;
      shadow_restore <= restore_now;
    end
  end

  // Table pointer and adjust mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= `RST_PTR;
      table_addr <= `RST_PTR;
      table_mode <= TM_NONE;
    end else if (tbl_now) begin
      table_mode <= mode_d;
      table_addr <= (mode_d == TM_PRE_INC) ? ptr_q + `TBL_STEP : ptr_q;
      unique case (mode_d)
        TM_NONE: ptr_q <= ptr_q;
        TM_POST_INC: ptr_q <= ptr_q + `TBL_STEP;
        TM_POST_DEC: ptr_q <= ptr_q - `TBL_STEP;
        TM_PRE_INC: ptr_q <= ptr_q + `TBL_STEP;
      endcase
    end else if (reg_write && (reg_addr == `REG_TBL_PTR)) begin
      ptr_q <= reg_wdata[20:0];
    end
  end

  // Table latch: loaded from memory the cycle after a read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= `RST_BYTE;
    end else if (table_rd) begin
      latch_q <= table_rdata;
    end else if (reg_write && (reg_addr == `REG_TBL_LATCH)) begin
      latch_q <= reg_wdata[7:0];
    end
  end
  assign table_wdata = latch_q;

  // Accumulator
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= `RST_BYTE;
    end else if (restore_now) begin
      acc_q <= sh_acc_q;
    end else if (exec_now && (cls == CL_BYTE) && !word1[`FLD_D]) begin
      acc_q <= alu_result;
    end else if (reg_write && (reg_addr == `REG_ACC)) begin
      acc_q <= reg_wdata[7:0];
    end
  end

  // Bank pointer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bank_q <= `RST_BANK;
    end else if (restore_now) begin
      bank_q <= sh_bank_q;
    end else if (reg_write && (reg_addr == `REG_BANK)) begin
      bank_q <= reg_wdata[3:0];
    end
  end

  // Status flags: only the masked flags change on execution, other than a fast return, which restores all five
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= `RST_FLAGS;
    end else if (restore_now) begin
      status_q <= sh_status_q;
    end else if (exec_now) begin
      status_q <= (status_q & ~flag_mask) | (alu_flags & flag_mask);
    end else if (reg_write && (reg_addr == `REG_STATUS)) begin
      status_q <= reg_wdata[4:0];
    end
  end

  // Product bytes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prod_lo_q <= `RST_BYTE;
      prod_hi_q <= `RST_BYTE;
    end else if (exec_now && (cls == CL_MULT)) begin
      prod_lo_q <= prod_full[7:0];
      prod_hi_q <= prod_full[15:8];
    end
  end

  // Shadow registers, written only by a fast call
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_acc_q <= `RST_BYTE;
      sh_bank_q <= `RST_BANK;
      sh_status_q <= `RST_FLAGS;
    end else if (save_now) begin
      sh_acc_q <= acc_q;
      sh_bank_q <= bank_q;
      sh_status_q <= status_q;
    end
  end

  // Register read mux
  always_comb begin
    unique case (reg_addr)
      `REG_BANK: rd_d = 32'(bank_q);
      `REG_ACC: rd_d = 32'(acc_q);
      `REG_STATUS: rd_d = 32'(status_q);
      `REG_PROD_LO: rd_d = 32'(prod_lo_q);
      `REG_PROD_HI: rd_d = 32'(prod_hi_q);
      `REG_TBL_PTR: rd_d = 32'(ptr_q);
      `REG_TBL_LATCH: rd_d = 32'(latch_q);
      `REG_SHADOW: rd_d = 32'({sh_status_q, sh_bank_q, sh_acc_q});
      `REG_SEQ: rd_d = 32'({class_q, state_q});
      default: rd_d = `RST_DATA;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `RST_DATA;
    end else begin
      reg_rdata <= reg_read ? rd_d : `RST_DATA;
    end
  end

  access_map_a: assert property (@(posedge clk) disable iff (!resetn)
    exec_valid && (exec_class == CL_BYTE) && access_window |->
    file_addr[11:8] == ((file_addr[7:0] < ACCESS_SPLIT) ? `ACC_LO_PAGE : `ACC_HI_PAGE))
    else $error("access window page wrong");

  dest_route_a: assert property (@(posedge clk) disable iff (!resetn)
    exec_valid && (exec_class == CL_BYTE) |-> file_we == dest_file)
    else $error("destination routing wrong");

  bit_select_a: assert property (@(posedge clk) disable iff (!resetn)
    exec_valid && (exec_class == CL_BIT) |-> bit_mask == (`BIT_ONE << bit_index))
    else $error("bit mask does not match index");

  cycle_span_a: assert property (@(posedge clk) disable iff (!resetn)
    cycle_en |=> !cycle_en [*3] ##1 cycle_en)
    else $error("instruction cycle not four clocks");

  double_word_a: assert property (@(posedge clk) disable iff (!resetn)
    cycle_en && (state_q == ST_FIRST) && !lone_second && is_double(instr_class) |=>
    !exec_valid [*4] ##1 exec_valid)
    else $error("double word did not take two cycles");

  lone_second_a: assert property (@(posedge clk) disable iff (!resetn)
    cycle_en && (state_q == ST_FIRST) && lone_second |=>
    nop_cycle && !exec_valid && !file_we && !table_rd && !table_wr)
    else $error("lone second word not a no-operation");

  flush_cycle_a: assert property (@(posedge clk) disable iff (!resetn)
    cycle_en && (state_q == ST_FIRST) && !lone_second && !is_double(instr_class) &&
    (cond_true || is_jump(instr_class)) |=> exec_valid ##4 nop_cycle)
    else $error("missing flush cycle");

  table_post_a: assert property (@(posedge clk) disable iff (!resetn)
    table_rd && (table_mode == TM_POST_INC) |-> ptr_q == 21'(table_addr + `TBL_STEP))
    else $error("post increment wrong");

  product_a: assert property (@(posedge clk) disable iff (!resetn)
    exec_valid && (exec_class == CL_MULT) |->
    {prod_hi_q, prod_lo_q} == 16'($past(acc_q)) * 16'($past(file_rdata)))
    else $error("product bytes wrong");

  flag_keep_a: assert property (@(posedge clk) disable iff (!resetn)
    exec_valid && !$past(reg_write) && !shadow_restore |->
    ((status_q ^ $past(status_q)) & ~$past(flag_mask)) == 5'h00)
    else $error("unlisted flag changed");

  shadow_back_a: assert property (@(posedge clk) disable iff (!resetn)
    shadow_restore |-> (acc_q == sh_acc_q) && (bank_q == sh_bank_q))
    else $error("shadow restore wrong");
endmodule

// ---- rtl/ofd_map.svh ----
// Named constants for the operand field decoder
// Overview of operation
// - Access bit zero uses the access window; one takes the bank from the bank pointer.
// - Destination bit zero writes the accumulator; one writes the addressed file register.
// - Three-bit index picks one of eight bits in the addressed byte.
// - Short file address is eight bits, 0x00 to 0xFF, in bank or window.
// - Two-word move carries full twelve-bit source and destination addresses.
// - Literal decodes as 8, 12 or 20 bits depending on the instruction.
// - Table mode: unchanged, post-increment, post-decrement or pre-increment, table ops only.
// - Table pointer is 21 bits; transfers pass through an 8-bit latch.
// - Fast bit saves to shadows on call, restores on return; zero leaves them.
// - Branch operand is signed offset when relative, absolute target otherwise.
// - Don't-care bits never change the decoded operation.
// - Multiply result lands in separate product high and low bytes.
// - Five status flags kept; each instruction but a fast return updates only its listed flags.
// - Second words carry ones on top; executed alone they act as no-operation.
// - One instruction cycle is exactly four oscillator periods.
// - Single word takes one cycle; taken test or jump adds a no-operation cycle.
// - Double-word instructions take two instruction cycles.
`ifndef OFD_MAP_SVH
`define OFD_MAP_SVH
`define FLD_F_MSB 7
`define FLD_F_LSB 0
`define FLD_A 8
`define FLD_D 9
`define FLD_B_MSB 11
`define FLD_B_LSB 9
`define FLD_S 0
`define FLD_S_CALL 8
`define FLD_MM_MSB 1
`define FLD_MM_LSB 0
`define FLD_W12_MSB 11
`define FLD_N11_MSB 10
`define FLD_K4_MSB 3
`define FLD_TOP_MSB 15
`define FLD_TOP_LSB 12
`define TOP_SECOND 4'hf
`define ACC_LO_PAGE 4'h0
`define ACC_HI_PAGE 4'hf
`define ACC_SPLIT 8'h80
`define CYC_PHASES 4
`define TBL_STEP 21'h0_0001
`define BIT_ONE 8'h01
`define RST_WORD 16'h0000
`define RST_BYTE 8'h00
`define RST_BANK 4'h0
`define RST_FLAGS 5'h00
`define RST_ADDR 12'h000
`define RST_LIT 20'h0_0000
`define RST_PTR 21'h0_0000
`define RST_DATA 32'h0000_0000
`define REG_BANK 4'h0
`define REG_ACC 4'h1
`define REG_STATUS 4'h2
`define REG_PROD_LO 4'h3
`define REG_PROD_HI 4'h4
`define REG_TBL_PTR 4'h5
`define REG_TBL_LATCH 4'h6
`define REG_SHADOW 4'h7
`define REG_SEQ 4'h8
`endif

// ---- rtl/ofd_pkg.sv ----
// Types shared by the operand field decoder
package ofd_pkg;
  // Operand layout class, given by the opcode decoder outside
  typedef enum logic [3:0] {
    CL_NOP = 4'h0,
    CL_BYTE = 4'h1,
    CL_BIT = 4'h2,
    CL_LIT8 = 4'h3,
    CL_LIT12 = 4'h4,
    CL_MOVE_FF = 4'h5,
    CL_GOTO = 4'h6,
    CL_CALL = 4'h7,
    CL_RETURN = 4'h8,
    CL_BRA11 = 4'h9,
    CL_BRANCH8 = 4'ha,
    CL_RCALL = 4'hb,
    CL_TBL_RD = 4'hc,
    CL_TBL_WR = 4'hd,
    CL_MULT = 4'he
  } instr_class_t;
  // Table pointer adjust modes
  typedef enum logic [1:0] {
    TM_NONE = 2'h0,
    TM_POST_INC = 2'h1,
    TM_POST_DEC = 2'h2,
    TM_PRE_INC = 2'h3
  } table_mode_t;
  // Instruction sequencer, one-hot
  typedef enum logic [2:0] {
    ST_FIRST = 3'b001,
    ST_SECOND = 3'b010,
    ST_FLUSH = 3'b100
  } seq_state_t;
  // Flags: bit0 carry, 1 digit carry, 2 zero, 3 signed range, 4 negative
  typedef logic [4:0] flags_t;
endpackage

// ---- rtl/cycle_divider.sv ----
// Divider giving one enable pulse per instruction cycle
`timescale 1ns/1ps
`include "ofd_map.svh"
module cycle_divider #(
  parameter int PHASES = `CYC_PHASES
) (
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);
  localparam int CW = (PHASES > 1) ? $clog2(PHASES) : 1;
  localparam logic [CW-1:0] LAST = CW'(PHASES - 1);
  logic [CW-1:0] cnt_q;

  // Phase counter wraps after the last oscillator period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Pulse on the final phase
  assign tick = (cnt_q == LAST);
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the operand field decoder
`timescale 1ns/1ps
`include "ofd_map.svh"
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("unexpected %s exp=%h got=%h", nm, e, g); \
    end \
  end
module testbench;
  import ofd_pkg::*;
  logic clk, resetn, cond_true, reg_write, reg_read;
  logic [15:0] instr_word;
  instr_class_t instr_class, exec_class;
  flags_t flag_mask, alu_flags;
  logic [7:0] alu_result, file_rdata, table_rdata, file_wdata, bit_mask, table_wdata;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic cycle_en, exec_valid, nop_cycle, access_window, dest_file, file_we, branch_rel;
  logic table_rd, table_wr, shadow_save, shadow_restore;
  logic [11:0] file_addr, move_src_addr, move_dst_addr;
  logic [2:0] bit_index;
  logic [19:0] literal, branch_value;
  table_mode_t table_mode;
  logic [20:0] table_addr, p, ea;
  int num_errors, n_tests, i, k;
  logic [7:0] bf [4] = '{8'h12, 8'h85, 8'h00, 8'hff};
  logic ba [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic [11:0] bx [4] = '{12'h012, 12'hf85, 12'h500, 12'h5ff};

  operand_field_decoder DUT (.clk(clk), .resetn(resetn), .instr_word(instr_word),
    .instr_class(instr_class), .cond_true(cond_true), .flag_mask(flag_mask),
    .alu_flags(alu_flags), .alu_result(alu_result), .file_rdata(file_rdata),
    .table_rdata(table_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .cycle_en(cycle_en),
    .exec_valid(exec_valid), .exec_class(exec_class), .nop_cycle(nop_cycle),
    .file_addr(file_addr), .access_window(access_window), .dest_file(dest_file),
    .file_we(file_we), .file_wdata(file_wdata), .bit_index(bit_index), .bit_mask(bit_mask),
    .literal(literal), .branch_rel(branch_rel), .branch_value(branch_value),
    .move_src_addr(move_src_addr), .move_dst_addr(move_dst_addr), .table_rd(table_rd),
    .table_wr(table_wr), .table_mode(table_mode), .table_addr(table_addr),
    .table_wdata(table_wdata), .shadow_save(shadow_save), .shadow_restore(shadow_restore));

  // Clock source
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic end_sim;
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Register write, one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // Register read, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  // Present one word until the next taking edge, then idle
  task automatic issue(input logic [15:0] w, input instr_class_t c, input logic ct);
    int j;
    for (j = 0; j < 8; j++) begin
      @(posedge clk);
      instr_word <= w;
      instr_class <= c;
      cond_true <= ct;
      #1;
      if (cycle_en === 1'b1) break;
    end
    if (j == 8) begin
      num_errors++;
      end_sim();
    end else begin
      @(posedge clk);
      instr_word <= 16'h0000;
      instr_class <= CL_NOP;
      cond_true <= 1'b0;
      #1;
    end
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    {cond_true, reg_write, reg_read} = 3'b000;
    instr_word = 16'h0000;
    instr_class = CL_NOP;
    {flag_mask, alu_flags} = 10'h000;
    {alu_result, file_rdata, table_rdata} = 24'h00_0000;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(4'h0, 32'h0000_0000);
    rd(4'h5, 32'h0000_0000);
    rd(4'h9, 32'h0000_0000);
    wr(4'h3, 32'h0000_00ff);
    rd(4'h3, 32'h0000_0000);
    // Spacing of instruction cycles
    for (i = 0; i < 8 && cycle_en !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    for (i = 1; i < 8 && cycle_en !== 1'b1; i++) @(negedge clk);
    `CHK("cycle_period", 4, i)
    // Byte operands, window and bank addressing
    wr(4'h0, 32'h0000_0005);
    for (k = 0; k < 4; k++) begin
      alu_result <= 8'h20 + 8'(k);
      issue({6'b001001, k[0], ba[k], bf[k]}, CL_BYTE, 1'b0);
      `CHK("file_addr", bx[k], file_addr)
      `CHK("access_window", !ba[k], access_window)
      `CHK("dest_file", k[0], dest_file)
      `CHK("file_we", k[0], file_we)
    end
    `CHK("file_wdata", 8'h23, file_wdata)
    rd(4'h1, 32'h0000_0022);
    // Bit operands
    for (k = 0; k < 8; k++) begin
      issue({4'b1000, k[2:0], 1'b0, 8'h40}, CL_BIT, 1'b0);
      `CHK("bit_index", k[2:0], bit_index)
      `CHK("bit_mask", `BIT_ONE << k, bit_mask)
      `CHK("file_addr", 12'h040, file_addr)
    end
    // Literals and double words
    issue(16'h0e7f, CL_LIT8, 1'b0);
    `CHK("literal", 20'h0_007f, literal)
    issue(16'hee0a, CL_LIT12, 1'b0);
    `CHK("exec_valid", 1'b0, exec_valid)
    issue(16'hf0bc, CL_LIT12, 1'b0);
    `CHK("exec_valid", 1'b1, exec_valid)
    `CHK("literal", 20'h0_0abc, literal)
    issue(16'hef34, CL_GOTO, 1'b0);
    issue(16'hfabc, CL_GOTO, 1'b0);
    `CHK("literal", 20'ha_bc34, literal)
    `CHK("branch_rel", 1'b0, branch_rel)
    `CHK("branch_value", 20'ha_bc34, branch_value)
    file_rdata <= 8'h5a;
    issue(16'hc123, CL_MOVE_FF, 1'b0);
    issue(16'hffed, CL_MOVE_FF, 1'b0);
    `CHK("move_src_addr", 12'h123, move_src_addr)
    `CHK("move_dst_addr", 12'hfed, move_dst_addr)
    `CHK("file_we", 1'b1, file_we)
    `CHK("file_wdata", 8'h5a, file_wdata)
    issue(16'hf123, CL_NOP, 1'b0);
    `CHK("nop_cycle", 1'b1, nop_cycle)
    // Branches and flush cycles
    issue(16'hd7fe, CL_BRA11, 1'b0);
    `CHK("branch_rel", 1'b1, branch_rel)
    `CHK("branch_value", 20'hf_fffe, branch_value)
    issue(16'h0000, CL_NOP, 1'b0);
    `CHK("nop_cycle", 1'b1, nop_cycle)
    issue(16'he205, CL_BRANCH8, 1'b1);
    `CHK("branch_value", 20'h0_0005, branch_value)
    issue(16'h0000, CL_NOP, 1'b0);
    `CHK("nop_cycle", 1'b1, nop_cycle)
    issue(16'he2fb, CL_BRANCH8, 1'b0);
    `CHK("branch_value", 20'hf_fffb, branch_value)
    issue(16'h0000, CL_NOP, 1'b0);
    `CHK("nop_cycle", 1'b0, nop_cycle)
    issue(16'hd805, CL_RCALL, 1'b0);
    `CHK("exec_class", CL_RCALL, exec_class)
    `CHK("branch_value", 20'h0_0005, branch_value)
    issue(16'h0000, CL_NOP, 1'b0);
    `CHK("nop_cycle", 1'b1, nop_cycle)
    // Multiply into product bytes
    wr(4'h1, 32'h0000_0012);
    file_rdata <= 8'h34;
    issue(16'h0234, CL_MULT, 1'b0);
    `CHK("exec_class", CL_MULT, exec_class)
    rd(4'h3, 32'h0000_00a8);
    rd(4'h4, 32'h0000_0003);
    // Masked status update
    wr(4'h2, 32'h0000_0000);
    flag_mask <= 5'b00101;
    alu_flags <= 5'h1f;
    issue({6'b001001, 1'b1, 1'b0, 8'h10}, CL_BYTE, 1'b0);
    flag_mask <= 5'b00000;
    rd(4'h2, 32'h0000_0005);
    // Fast call and return shadows
    // Status written off the execute edge, where an executing word wins
    wr(4'h0, 32'h0000_0003);
    wr(4'h2, 32'h0000_000a);
    wr(4'h1, 32'h0000_0044);
    issue(16'hed34, CL_CALL, 1'b0);
    issue(16'hf000, CL_CALL, 1'b0);
    `CHK("shadow_save", 1'b1, shadow_save)
    rd(4'h7, 32'h0000_a344);
    wr(4'h1, 32'h0000_0000);
    wr(4'h0, 32'h0000_0000);
    issue(16'h0013, CL_RETURN, 1'b0);
    `CHK("shadow_restore", 1'b1, shadow_restore)
    issue(16'h0000, CL_NOP, 1'b0);
    `CHK("nop_cycle", 1'b1, nop_cycle)
    rd(4'h1, 32'h0000_0044);
    rd(4'h0, 32'h0000_0003);
    wr(4'h1, 32'h0000_0055);
    issue(16'h0012, CL_RETURN, 1'b0);
    `CHK("shadow_restore", 1'b0, shadow_restore)
    issue(16'h0000, CL_NOP, 1'b0);
    rd(4'h1, 32'h0000_0055);
    // Table pointer modes near the top of the pointer range
    p = 21'h1f_fff0;
    wr(4'h5, {11'h000, p});
    table_rdata <= 8'h3c;
    for (k = 0; k < 4; k++) begin
      ea = (k == 3) ? p + 21'h1 : p;
      p = (k == 1 || k == 3) ? p + 21'h1 : (k == 2) ? p - 21'h1 : p;
      issue(16'h0008 | 16'(k), CL_TBL_RD, 1'b0);
      `CHK("table_rd", 1'b1, table_rd)
      `CHK("table_mode", table_mode_t'(k), table_mode)
      `CHK("table_addr", ea, table_addr)
      rd(4'h5, {11'h000, p});
    end
    rd(4'h6, 32'h0000_003c);
    issue(16'h000c, CL_TBL_WR, 1'b0);
    `CHK("table_wr", 1'b1, table_wr)
    `CHK("table_rd", 1'b0, table_rd)
    `CHK("table_wdata", 8'h3c, table_wdata)
    end_sim();
  end
endmodule
